// File: nahi_buf.sv
// two-entry valid/ready buffer for read data
module nahi_buf #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem [2];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    // full and empty follow the entry count
    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];

    // pointers and count
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) wr_ptr <= ~wr_ptr;
            if (pop) rd_ptr <= ~rd_ptr;
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage carries no reset
    always_ff @(posedge clk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end
endmodule

// File: nahi_dev_model.sv
// behavioural nand target model answering the host controller pins
module nahi_dev_model #(
    parameter int PWR_NS  = 200,
    parameter int RST_NS  = 1000,
    parameter int HOLD_NS = 15
) (
    // control pins from the host
    input  wire logic       chip_en_n_i,
    input  wire logic       cmd_latch_i,
    input  wire logic       addr_latch_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic       write_prot_n_i,
    // shared data bus and ready/busy pull-down
    input  wire logic [7:0] io_i,
    output logic      [7:0] io_o,
    output logic            rb_pull_o,
    // capture log for the bench
    output logic      [1:0] cap_kind_o,
    output logic      [7:0] cap_byte_o,
    output int              cap_cnt_o,
    output int              bad_cnt_o
);
    logic [7:0] cache [0:255];
    logic [7:0] col  = 8'h00;
    logic       busy = 1'b1;
    logic       stat = 1'b0;
    logic       enh  = 1'b0;
    int         acnt = 0;

    // busy through power-up
    initial begin
        io_o = 8'h5A;
        cap_kind_o = 2'h0;
        cap_byte_o = 8'h00;
        cap_cnt_o = 0;
        bad_cnt_o = 0;
        #(PWR_NS);
        busy = 1'b0;
    end
    assign rb_pull_o = busy;

    task automatic cap(input logic [1:0] k);
        cap_kind_o = k;
        cap_byte_o = io_i;
        cap_cnt_o = cap_cnt_o + 1;
    endtask

    // write strobe rise latches a byte
    always @(posedge write_strobe_n_i) begin
        if (!chip_en_n_i && read_strobe_n_i) begin
            if (cmd_latch_i && addr_latch_i) begin
                bad_cnt_o = bad_cnt_o + 1;
            end else if (cmd_latch_i) begin
                if (!busy || io_i == 8'h70 || io_i == 8'h78) begin
                    cap(2'h0);
                    stat = (io_i == 8'h70) || (io_i == 8'h78);
                    enh = (io_i == 8'h78);
                    acnt = 0;
                    if (io_i == 8'hFF) begin
                        busy = 1'b1;
                        fork
                            #(RST_NS) busy = 1'b0;
                        join_none
                    end
                end
            end else if (addr_latch_i) begin
                if (!busy || enh) begin
                    cap(2'h1);
                    if (acnt == 0) col = io_i;
                    acnt = acnt + 1;
                end
            end else if (!busy) begin
                cap(2'h2);
                cache[col] = io_i;
                col = col + 8'h01;
            end
        end
    end

    // read strobe fall drives next byte or status
    always @(negedge read_strobe_n_i) begin
        if (!chip_en_n_i && !cmd_latch_i && !addr_latch_i && write_strobe_n_i) begin
            if (stat) begin
                io_o <= #4 {write_prot_n_i, !busy, 6'h00};
            end else if (!busy) begin
                io_o <= #4 cache[col];
                col = col + 8'h01;
            end
        end
    end

    // data lapses after hold or on standby
    always @(posedge read_strobe_n_i or posedge chip_en_n_i) begin
        #(HOLD_NS) io_o = ~io_o;
    end

    // both strobes low while selected is an illegal cycle
    always @(negedge write_strobe_n_i or negedge read_strobe_n_i) begin
        if (!chip_en_n_i && !write_strobe_n_i && !read_strobe_n_i) bad_cnt_o = bad_cnt_o + 1;
    end
endmodule

// File: nahi_host.sv
// host controller driving the nand asynchronous pins
module nahi_host #(
    parameter int PWRUP_CYC   = nahi_pkg::PWRUP_NOMON_CYC,
    parameter int RSTBSY_CYC  = nahi_pkg::RESET_BUSY_CYC,
    parameter bit USE_RB      = 1'b1
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // request port
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire logic [2:0]  req_op_i,
    input  wire logic [7:0]  req_byte_i,
    input  wire logic [12:0] req_col_i,
    input  wire logic [22:0] req_row_i,
    // read data stream
    output logic             rd_valid_o,
    input  wire logic        rd_ready_i,
    output logic [7:0]       rd_data_o,
    // status
    output logic             init_done_o,
    output logic             busy_o,
    output logic             addr_err_o,
    // nand pins
    output logic             chip_en_n_o,
    output logic             cmd_latch_o,
    output logic             addr_latch_o,
    output logic             write_strobe_n_o,
    output logic             read_strobe_n_o,
    output logic             write_prot_n_o,
    output logic [7:0]       io_o,
    output logic             io_oe_n_o,
    input  wire logic [7:0]  io_i,
    input  wire logic        ready_busy_n_i
);
    localparam int CW = 24;
    nahi_pkg::nahi_state_t state;
    nahi_pkg::nahi_state_t next_state;
    logic [CW-1:0] cnt;
    logic [2:0]    acyc;
    logic [2:0]    op;
    logic [12:0]   col;
    logic [22:0]   row;
    logic [7:0]    wbyte;
    logic          rb_sync;
    logic [7:0]    io_sync;
    logic          buf_ready;
    logic          push;
    logic          addr_bad;

    // pin inputs pass two flip-flops first
    nahi_sync #(.WIDTH(1), .INIT(32'h0)) u_rb_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .async_i(ready_busy_n_i),
        .sync_o (rb_sync)
    );
    nahi_sync #(.WIDTH(8), .INIT(32'h0)) u_io_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .async_i(io_i),
        .sync_o (io_sync)
    );

    // read data buffer; a full buffer holds the read strobe low in RLOW until an entry drains
    nahi_buf #(.WIDTH(8)) u_buf (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .in_valid_i (push),
        .in_ready_o (buf_ready),
        .in_data_i  (io_sync),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o (rd_data_o)
    );

    // decode of request legality and phase
    wire idle      = (state == nahi_pkg::NAHI_S_IDLE);
    wire take      = req_valid_i && req_ready_o;
    wire cnt_zero  = (cnt == '0);
    wire is_cmd    = (op == nahi_pkg::NAHI_OP_CMD);
    wire is_addr   = (op == nahi_pkg::NAHI_OP_ADDR5) || (op == nahi_pkg::NAHI_OP_ADDR1);
    wire is_read   = (op == nahi_pkg::NAHI_OP_READ);
    wire last_addr = (op == nahi_pkg::NAHI_OP_ADDR1) || (acyc == nahi_pkg::ADDR_CYC_LAST);
    // column top bit set with bits 11..8 nonzero is refused
    assign addr_bad = (req_op_i == nahi_pkg::NAHI_OP_ADDR5)
                   && req_col_i[nahi_pkg::COL_TOP] && (req_col_i[11:8] != 4'h0);
    // reading data out needs ready so the die is not busy
    wire rb_gate   = rb_sync || !USE_RB;
    assign req_ready_o = idle && !addr_bad && (rb_gate || req_op_i == nahi_pkg::NAHI_OP_CMD);
    assign push    = (state == nahi_pkg::NAHI_S_RLOW) && cnt_zero && buf_ready;
    assign busy_o  = !idle;

    // address byte for the current cycle, unused bits forced low
    logic [7:0] abyte;
    always_comb begin
        abyte = 8'h00;
        case (acyc)
            3'h0:    abyte = col[7:0];
            3'h1:    abyte = {3'h0, col[12:8]};
            3'h2:    abyte = row[7:0];
            3'h3:    abyte = row[15:8];
            default: abyte = {1'b0, row[22:16]} & 8'h01;
        endcase
    end

    // next state
    always_comb begin
        next_state = state;
        case (state)
            nahi_pkg::NAHI_S_PWRUP: begin
                if (cnt_zero && rb_gate) next_state = nahi_pkg::NAHI_S_RSTCMD;
            end
            nahi_pkg::NAHI_S_RSTCMD: begin
                if (cnt_zero) next_state = nahi_pkg::NAHI_S_RSTBSY;
            end
            nahi_pkg::NAHI_S_RSTBSY: begin
                if (cnt_zero && rb_gate) next_state = nahi_pkg::NAHI_S_IDLE;
            end
            nahi_pkg::NAHI_S_IDLE: begin
                if (take && req_op_i == nahi_pkg::NAHI_OP_WP) begin
                    next_state = nahi_pkg::NAHI_S_SETTLE;
                end else if (take && req_ready_o) begin
                    next_state = nahi_pkg::NAHI_S_SETUP;
                end
            end
            nahi_pkg::NAHI_S_SETUP: begin
                next_state = is_read ? nahi_pkg::NAHI_S_RLOW : nahi_pkg::NAHI_S_WLOW;
            end
            nahi_pkg::NAHI_S_WLOW: begin
                if (cnt_zero) next_state = nahi_pkg::NAHI_S_WHIGH;
            end
            nahi_pkg::NAHI_S_WHIGH: begin
                if (cnt_zero) begin
                    next_state = (is_addr && !last_addr) ? nahi_pkg::NAHI_S_WLOW
                                                         : nahi_pkg::NAHI_S_IDLE;
                end
            end
            nahi_pkg::NAHI_S_RLOW: begin
                if (push) next_state = nahi_pkg::NAHI_S_RHIGH;
            end
            nahi_pkg::NAHI_S_RHIGH: begin
                if (cnt_zero) next_state = nahi_pkg::NAHI_S_IDLE;
            end
            nahi_pkg::NAHI_S_SETTLE: begin
                if (cnt_zero) next_state = nahi_pkg::NAHI_S_IDLE;
            end
            default: next_state = nahi_pkg::NAHI_S_PWRUP;
        endcase
    end

    // next count loaded on each state entry
    logic [CW-1:0] next_cnt;
    always_comb begin
        next_cnt = cnt_zero ? cnt : cnt - 1'b1;
        if (next_state != state || (state == nahi_pkg::NAHI_S_WHIGH && next_state
                == nahi_pkg::NAHI_S_WLOW)) begin
            case (next_state)
                // reset command gets a high phase so latches hold past the strobe rise
                nahi_pkg::NAHI_S_RSTCMD:
                    next_cnt = CW'(nahi_pkg::STRB_LOW_CYC + nahi_pkg::STRB_HIGH_CYC - 1);
                nahi_pkg::NAHI_S_RSTBSY: next_cnt = CW'(RSTBSY_CYC - 1);
                nahi_pkg::NAHI_S_WLOW:   next_cnt = CW'(nahi_pkg::STRB_LOW_CYC - 1);
                // two extra cycles cover the io synchroniser before the push
                nahi_pkg::NAHI_S_RLOW:   next_cnt = CW'(nahi_pkg::STRB_LOW_CYC + 1);
                nahi_pkg::NAHI_S_WHIGH:  next_cnt = CW'(nahi_pkg::STRB_HIGH_CYC - 1);
                nahi_pkg::NAHI_S_RHIGH:  next_cnt = CW'(nahi_pkg::STRB_HIGH_CYC - 1);
                nahi_pkg::NAHI_S_SETTLE: next_cnt = CW'(nahi_pkg::PROTECT_SETTLE_CYC - 1);
                default:                 next_cnt = '0;
            endcase
        end
    end

    // state and counter
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= nahi_pkg::NAHI_S_PWRUP;
            cnt   <= CW'(PWRUP_CYC - 1);
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // request capture and address cycle index
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            op    <= 3'h0;
            col   <= 13'h0000;
            row   <= 23'h000000;
            wbyte <= nahi_pkg::CMD_RESET;
            acyc  <= 3'h0;
        end else if (state == nahi_pkg::NAHI_S_IDLE && next_state == nahi_pkg::NAHI_S_SETUP) begin
            op    <= req_op_i;
            col   <= req_col_i;
            row   <= req_row_i;
            wbyte <= req_byte_i;
            acyc  <= 3'h0;
        end else if (state == nahi_pkg::NAHI_S_WHIGH && cnt_zero) begin
            acyc  <= acyc + 3'h1;
        end
    end

    // write protect held low until init, then steered by requests
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            write_prot_n_o <= 1'b0;
        end else if (take && req_op_i == nahi_pkg::NAHI_OP_WP) begin
            write_prot_n_o <= req_byte_i[0];
        end
    end

    // pin drive from registers
    wire in_w   = (state == nahi_pkg::NAHI_S_WLOW) || (state == nahi_pkg::NAHI_S_WHIGH);
    wire in_r   = (state == nahi_pkg::NAHI_S_RLOW) || (state == nahi_pkg::NAHI_S_RHIGH);
    wire in_rst = (state == nahi_pkg::NAHI_S_RSTCMD);
    wire rst_lo = in_rst && (cnt >= CW'(nahi_pkg::STRB_HIGH_CYC));
    wire selct  = in_w || in_r || in_rst || (state == nahi_pkg::NAHI_S_SETUP);
    logic [7:0] next_io;
    assign next_io = is_addr ? abyte : wbyte;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            chip_en_n_o      <= 1'b1;
            cmd_latch_o      <= 1'b0;
            addr_latch_o     <= 1'b0;
            write_strobe_n_o <= 1'b1;
            read_strobe_n_o  <= 1'b1;
            io_o             <= 8'h00;
            io_oe_n_o        <= 1'b1;
            init_done_o      <= 1'b0;
            addr_err_o       <= 1'b0;
        end else begin
            // chip enable released between requests lets the die drop to standby
            chip_en_n_o      <= !selct;
            cmd_latch_o      <= in_rst || (in_w && is_cmd);
            addr_latch_o     <= in_w && is_addr && !in_rst;
            // rising edge of the write strobe at end of WLOW latches the byte
            write_strobe_n_o <= !(rst_lo || (state == nahi_pkg::NAHI_S_WLOW));
            read_strobe_n_o  <= !(state == nahi_pkg::NAHI_S_RLOW);
            io_o             <= in_rst ? nahi_pkg::CMD_RESET : next_io;
            io_oe_n_o        <= !(in_rst || in_w || (state == nahi_pkg::NAHI_S_SETUP && !is_read));
            init_done_o      <= init_done_o || (state == nahi_pkg::NAHI_S_RSTBSY && next_state
                                == nahi_pkg::NAHI_S_IDLE);
            addr_err_o       <= idle && req_valid_i && addr_bad;
        end
    end

    // never both latches, never both strobes low
    AST_LATCH_EXCL: assert property (@(posedge clk_i) disable iff (srst_i)
        !(cmd_latch_o && addr_latch_o)) else $error("both latches high");
    AST_STRB_EXCL: assert property (@(posedge clk_i) disable iff (srst_i)
        !(!write_strobe_n_o && !read_strobe_n_o)) else $error("both strobes low");
    AST_FIRST_RESET: assert property (@(posedge clk_i) disable iff (srst_i)
        ($fell(write_strobe_n_o) && !init_done_o) |-> ##1 (io_o == nahi_pkg::CMD_RESET))
        else $error("first command not reset");
    AST_ADDR_HIGH_LOW: assert property (@(posedge clk_i) disable iff (srst_i)
        (addr_latch_o && acyc == 3'h4 && !write_strobe_n_o) |-> io_o[7:1] == 7'h00)
        else $error("fifth address cycle upper bits set");
    AST_WP_IDLE: assert property (@(posedge clk_i) disable iff (srst_i)
        $changed(write_prot_n_o) |-> ##1 (state == nahi_pkg::NAHI_S_SETTLE))
        else $error("write protect changed outside idle");
    AST_WP_PWRUP: assert property (@(posedge clk_i) disable iff (srst_i)
        !init_done_o |-> !write_prot_n_o) else $error("write protect high before init");
    AST_WE_HOLD: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(write_strobe_n_o) |-> !write_strobe_n_o [*2]) else $error("write strobe short");
    AST_CE_DATA: assert property (@(posedge clk_i) disable iff (srst_i)
        (!read_strobe_n_o || !write_strobe_n_o) |-> !chip_en_n_o)
        else $error("strobe without chip enable");
    AST_RB_DONE: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(init_done_o) |-> $past(rb_gate)) else $error("init done while busy");
    COV_RESET_DONE: cover property (@(posedge clk_i) disable iff (srst_i) $rose(init_done_o));
    COV_ADDR5: cover property (@(posedge clk_i) disable iff (srst_i)
        addr_latch_o && acyc == 3'h4);
    COV_READ: cover property (@(posedge clk_i) disable iff (srst_i) push);
    COV_WP: cover property (@(posedge clk_i) disable iff (srst_i) $rose(write_prot_n_o));
endmodule

// File: nahi_pkg.sv
// package of constants and types for the nand async host interface controller
// Operation
// - five address cycles: column, column, row x3
// - column top bit set forces bits 11..8 zero
// - bits outside address space driven low
// - command latched on write strobe rising edge
// - address latched on write strobe rising edge
// - data input latched on write strobe rise
// - sample on read rise when period long; the host samples io_i while the read strobe is still low
// - issue read mode after enhanced status read
// - change write protect only idle, then settle
// - hold write protect low during power-on
// - ready/busy valid after 50us/10us at power-up
// - without ready/busy wait 100us before command
// - reset first command, busy for 1ms
package nahi_pkg;
    // clock rate and derived cycle counts
    localparam int CLK_PERIOD_NS       = 10;
    localparam int STRB_LOW_NS         = 20;
    localparam int STRB_HIGH_NS        = 20;
    localparam int STRB_LOW_CYC        = (STRB_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRB_HIGH_CYC       = (STRB_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYCLE_NS       = STRB_LOW_NS + STRB_HIGH_NS;
    localparam int SAMPLE_LONG_NS      = 30;
    localparam int PWRUP_VALID_US      = 50;
    localparam int PWRUP_NOMON_US      = 100;
    localparam int RESET_BUSY_US       = 1000;
    localparam int PROTECT_SETTLE_NS   = 100;
    localparam int PWRUP_VALID_CYC     = (PWRUP_VALID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_NOMON_CYC     = (PWRUP_NOMON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_BUSY_CYC      = (RESET_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROTECT_SETTLE_CYC  = (PROTECT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // command codes
    localparam logic [7:0] CMD_RESET       = 8'hFF;
    localparam logic [7:0] CMD_READ_MODE   = 8'h00;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
    // address layout fields
    localparam int COL_W      = 13;
    localparam int PAGE_W     = 6;
    localparam int BLOCK_W    = 17;
    localparam int ROW_W      = PAGE_W + BLOCK_W;
    localparam int COL_TOP    = 12;
    localparam int ADDR_CYCLES = 5;
    localparam logic [2:0] ADDR_CYC_LAST = 3'h4;
    // request kinds
    typedef enum logic [2:0] {
        NAHI_OP_CMD   = 3'h0,
        NAHI_OP_ADDR5 = 3'h1,
        NAHI_OP_ADDR1 = 3'h2,
        NAHI_OP_WRITE = 3'h3,
        NAHI_OP_READ  = 3'h4,
        NAHI_OP_WP    = 3'h5
    } nahi_op_t;
    // sequencer states
    typedef enum logic [3:0] {
        NAHI_S_PWRUP  = 4'h0,
        NAHI_S_RSTCMD = 4'h1,
        NAHI_S_RSTBSY = 4'h2,
        NAHI_S_IDLE   = 4'h3,
        NAHI_S_SETUP  = 4'h4,
        NAHI_S_WLOW   = 4'h5,
        NAHI_S_WHIGH  = 4'h6,
        NAHI_S_RLOW   = 4'h7,
        NAHI_S_RHIGH  = 4'h8,
        NAHI_S_SETTLE = 4'h9
    } nahi_state_t;
endpackage

// File: nahi_sync.sv
// two flip-flop synchroniser for pin inputs
module nahi_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // asynchronous input and synchronised output
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second stage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            stage1 <= INIT[WIDTH-1:0];
            sync_o <= INIT[WIDTH-1:0];
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// File: nand_async_host_interface_tb.sv
// self-checking bench for the nand host controller against a target model
module nand_async_host_interface_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i       = 1'b0;
    logic        srst_i      = 1'b1;
    logic        req_valid_i = 1'b0;
    logic [2:0]  req_op_i    = 3'h0;
    logic [7:0]  req_byte_i  = 8'h00;
    logic [12:0] req_col_i   = 13'h0000;
    logic [22:0] req_row_i   = 23'h000000;
    logic        rd_ready_i  = 1'b0;
    logic        stall       = 1'b0;
    logic        req_ready_o, rd_valid_o, init_done_o, busy_o, addr_err_o, io_oe_n_o;
    logic        chip_en_n_o, cmd_latch_o, addr_latch_o, write_strobe_n_o, read_strobe_n_o;
    logic        write_prot_n_o, rb_pull, ready_busy_n_i, taken;
    logic [7:0]  rd_data_o, io_o, io_i, dev_io, cap_byte;
    logic [1:0]  cap_kind;
    int          cap_cnt, bad_cnt, n;
    int          errors      = 0;
    int          check_count = 0;
    int          seed        = 56538;
    logic [9:0]  exp_bus [$];
    logic [7:0]  exp_rd [$];
    logic [7:0]  wdat [4];
    logic [12:0] tcol;
    logic [22:0] trow;

    // io bus resolution; ready/busy pulled up
    assign io_i = (io_oe_n_o === 1'b0) ? io_o : dev_io;
    assign ready_busy_n_i = rb_pull ? 1'b0 : 1'b1;

    nahi_host #(.PWRUP_CYC(4), .RSTBSY_CYC(4), .USE_RB(1'b1)) u_nahi_host (.*);

    nahi_dev_model u_nahi_dev_model (
        .chip_en_n_i(chip_en_n_o), .cmd_latch_i(cmd_latch_o), .addr_latch_i(addr_latch_o),
        .write_strobe_n_i(write_strobe_n_o), .read_strobe_n_i(read_strobe_n_o),
        .write_prot_n_i(write_prot_n_o), .io_i(io_i), .io_o(dev_io), .rb_pull_o(rb_pull),
        .cap_kind_o(cap_kind), .cap_byte_o(cap_byte), .cap_cnt_o(cap_cnt),
        .bad_cnt_o(bad_cnt));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (e !== s) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic giveup(input string what);
        chk(what, 32'h1, 32'h0);
        summarize();
    endtask

    // hold request until taken
    task automatic req(input logic [2:0] op, input logic [7:0] b, input logic [12:0] c,
                       input logic [22:0] r, input bit wt);
        int k;
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_op_i = op;
        req_byte_i = b;
        req_col_i = c;
        req_row_i = r;
        #1;
        for (k = 0; k < 500 && req_ready_o !== 1'b1; k++) @(negedge clk_i);
        if (k >= 500) giveup("request taken");
        @(negedge clk_i);
        req_valid_i = 1'b0;
        for (k = 0; wt && k < 500 && busy_o !== 1'b0; k++) @(negedge clk_i);
        if (k >= 500) giveup("request done");
    endtask

    task automatic cmd(input logic [7:0] b, input bit seen);
        if (seen) exp_bus.push_back({2'h0, b});
        req(nahi_pkg::NAHI_OP_CMD, b, 13'h0000, 23'h000000, 1'b1);
    endtask

    task automatic addr5(input logic [12:0] c, input logic [22:0] r);
        exp_bus.push_back({2'h1, c[7:0]});
        exp_bus.push_back({2'h1, 3'h0, c[12:8]});
        exp_bus.push_back({2'h1, r[7:0]});
        exp_bus.push_back({2'h1, r[15:8]});
        exp_bus.push_back({2'h1, 7'h00, r[16]});
        req(nahi_pkg::NAHI_OP_ADDR5, 8'h00, c, r, 1'b1);
    endtask

    task automatic drain;
        int k;
        for (k = 0; k < 500 && exp_rd.size() > 0; k++) @(negedge clk_i);
        if (k >= 500) giveup("read drain");
    endtask

    // captures vs oldest note
    always @(cap_cnt) begin
        if (cap_cnt > 0 && exp_bus.size() == 0) begin
            chk("unexpected capture", 32'hFFFFFFFF, {22'h0, cap_kind, cap_byte});
        end else if (cap_cnt > 0) begin
            chk("bus capture", {22'h0, exp_bus.pop_front()}, {22'h0, cap_kind, cap_byte});
        end
    end

    // read stream vs oldest note
    always @(posedge clk_i) begin
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
            chk("read data", {24'h0, exp_rd.pop_front()}, {24'h0, rd_data_o});
        end
    end

    // random drain unless stalled
    always @(negedge clk_i) rd_ready_i <= stall ? 1'b0 : 1'($random(seed));

    initial begin
        exp_bus.push_back({2'h0, nahi_pkg::CMD_RESET});
        repeat (6) @(negedge clk_i);
        srst_i = 1'b0;
        chk("protect at power-up", 32'h0, {31'h0, write_prot_n_o});
        for (n = 0; n < 3000 && init_done_o !== 1'b1; n++) @(negedge clk_i);
        chk("init done", 32'h1, {31'h0, init_done_o});
        $display("test power-up done");
        cmd(nahi_pkg::CMD_STATUS, 1'b1);
        cmd(nahi_pkg::CMD_STATUS_ENH, 1'b1);
        exp_bus.push_back({2'h1, 8'h01});
        req(nahi_pkg::NAHI_OP_ADDR1, 8'h00, 13'h0001, 23'h000000, 1'b1);
        cmd(nahi_pkg::CMD_READ_MODE, 1'b1);
        $display("test command codes done");
        tcol = {1'b0, 4'($random(seed)), 8'($random(seed))};
        trow = 23'($random(seed));
        cmd(8'h80, 1'b1);
        addr5(tcol, trow);
        for (n = 0; n < 4; n++) begin
            wdat[n] = 8'($random(seed));
            exp_bus.push_back({2'h2, wdat[n]});
            req(nahi_pkg::NAHI_OP_WRITE, wdat[n], 13'h0000, 23'h000000, 1'b1);
        end
        cmd(nahi_pkg::CMD_READ_MODE, 1'b1);
        addr5(tcol, trow);
        for (n = 0; n < 4; n++) begin
            exp_rd.push_back(wdat[n]);
            req(nahi_pkg::NAHI_OP_READ, 8'h00, 13'h0000, 23'h000000, 1'b1);
        end
        drain();
        $display("test write and read back done");
        addr5({5'h10, 8'($random(seed))}, trow);
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_op_i = nahi_pkg::NAHI_OP_ADDR5;
        req_col_i = 13'h1F00 | 13'($random(seed) & 8'hFF);
        taken = 1'b0;
        for (n = 0; n < 20 && addr_err_o !== 1'b1; n++) begin
            #1 taken = taken | req_ready_o;
            @(negedge clk_i);
        end
        req_valid_i = 1'b0;
        chk("address refusal flag", 32'h1, {31'h0, addr_err_o});
        chk("bad address taken", 32'h0, {31'h0, taken});
        $display("test column boundary done");
        req(nahi_pkg::NAHI_OP_WP, 8'h01, 13'h0000, 23'h000000, 1'b1);
        chk("protect released", 32'h1, {31'h0, write_prot_n_o});
        cmd(nahi_pkg::CMD_STATUS, 1'b1);
        exp_rd.push_back(8'hC0);
        req(nahi_pkg::NAHI_OP_READ, 8'h00, 13'h0000, 23'h000000, 1'b1);
        drain();
        cmd(nahi_pkg::CMD_READ_MODE, 1'b1);
        req(nahi_pkg::NAHI_OP_WP, 8'h00, 13'h0000, 23'h000000, 1'b1);
        chk("protect applied", 32'h0, {31'h0, write_prot_n_o});
        $display("test write protect done");
        cmd(nahi_pkg::CMD_RESET, 1'b1);
        cmd(nahi_pkg::CMD_STATUS, 1'b1);
        cmd(8'h90, 1'b0);
        @(negedge clk_i);
        req_valid_i = 1'b1;
        req_op_i = nahi_pkg::NAHI_OP_READ;
        #1 chk("read refused while busy", 32'h0, {31'h0, req_ready_o});
        @(negedge clk_i);
        req_valid_i = 1'b0;
        for (n = 0; n < 500 && ready_busy_n_i !== 1'b1; n++) @(negedge clk_i);
        if (n >= 500) giveup("ready after reset");
        cmd(nahi_pkg::CMD_READ_MODE, 1'b1);
        $display("test busy target done");
        stall = 1'b1;
        addr5(tcol, trow);
        for (n = 0; n < 3; n++) begin
            exp_rd.push_back(wdat[n]);
            req(nahi_pkg::NAHI_OP_READ, 8'h00, 13'h0000, 23'h000000, n < 2);
        end
        repeat (20) @(negedge clk_i);
        chk("full buffer holds read", 32'h3, {30'h0, busy_o, rd_valid_o});
        stall = 1'b0;
        drain();
        for (n = 0; n < 500 && busy_o !== 1'b0; n++) @(negedge clk_i);
        if (n >= 500) giveup("stall end");
        $display("test read stall done");
        chk("captures pending", 32'h0, exp_bus.size());
        chk("illegal pin cycles", 32'h0, bad_cnt);
        summarize();
    end
endmodule
